/* File: core/sicr_pkg.sv */
// sicr_pkg: constants for the serial interface configuration register bank.
// assumes a 40 MHz system clock and a serial clock sampled by that clock.
package sicr_pkg;

	// register addresses (15-bit serial address space)
	localparam logic [14:0] ADDR_CFG_A      = 15'h0000;
	localparam logic [14:0] ADDR_CFG_B      = 15'h0001;
	localparam logic [14:0] ADDR_CHIP_CLASS = 15'h0003;
	localparam logic [14:0] ADDR_PROD_LOW   = 15'h0004;
	localparam logic [14:0] ADDR_PROD_HIGH  = 15'h0005;

	// field positions in interface_config_a
	localparam int BIT_FOUR_WIRE  = 3;
	localparam int BIT_STREAM_UP  = 2;
	localparam int BIT_LOW_FIRST  = 1;
	localparam int BIT_SELF_RESET = 0;
	// field positions in interface_config_b and the trigger vector
	localparam int BIT_AUX1 = 2;
	localparam int BIT_AUX0 = 1;
	localparam int CFG_B_HI = 3;

	// reset values
	localparam logic [3:1] CFG_A_RESET    = 3'h0;
	localparam logic [4:0] CFG_B_HI_RESET = 5'h00;

	// frame layout
	localparam logic [3:0] INSTR_LAST = 4'hF;
	localparam logic [3:0] BYTE_LAST  = 4'h7;
	localparam logic [7:0] UNMAPPED   = 8'h00;

	// soft reset pulse length, rounded up to whole clock cycles
	localparam int CLK_PERIOD_NS     = 25;
	localparam int RESET_PULSE_NS    = 100;
	localparam int RESET_PULSE_INT   = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] PULSE_CYC = 3'(RESET_PULSE_INT < 1 ? 1 : RESET_PULSE_INT);

	// transfer phase, one-hot
	typedef enum logic [2:0] {
		PH_IDLE  = 3'h1,
		PH_INSTR = 3'h2,
		PH_DATA  = 3'h4
	} sicr_phase_e;

	// whole state of the register bank
	typedef struct packed {
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_s3;
		logic        cs_n_s1;
		logic        cs_n_s2;
		logic        din_s1;
		logic        din_s2;
		sicr_phase_e phase;
		logic [3:0]  bit_cnt;
		logic [15:0] shift;
		logic        rw;
		logic [14:0] addr;
		logic [7:0]  out_byte;
		logic [3:1]  cfg_a;
		logic [4:0]  cfg_b_hi;
		logic [2:0]  trig;
		logic [8:0]  pulse_cnt;
		logic        sdio_out;
		logic        sdio_oe;
		logic        sdo_out;
		logic [2:0]  rst_out;
	} sicr_state_s;

endpackage

/* File: core/sicr_regs.sv */
// sicr_regs: serial port slave with the interface configuration and id registers.
// assumes SCLK, CS_N and SDIO come from pins; mode 0, host samples on the rising edge.
`timescale 1ns/100ps
module sicr_regs #(
	parameter logic [7:0]  CHIP_CLASS = 8'h5A,   // arbitrary value
	parameter logic [15:0] PART_ID    = 16'h1234 // arbitrary value
) (
	input  wire logic MCLK_IN,
	input  wire logic RST_IN,
	input  wire logic SPI_SCLK_IN,
	input  wire logic SPI_CS_N_IN,
	input  wire logic SPI_SDIO_IN,
	output logic      SPI_SDIO_OUT,
	output logic      SPI_SDIO_OE_OUT,
	output logic      SPI_SDO_OUT,
	output logic      SOFT_RESET_OUT,
	output logic      AUX_RESET0_OUT,
	output logic      AUX_RESET1_OUT
);
	import sicr_pkg::*;

	sicr_state_s st_reg;
	sicr_state_s st_next;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        byte_end;
	logic        instr_end;
	logic        low_first;
	logic [15:0] sh_new;
	logic [15:0] word;
	logic [7:0]  wr_byte;
	logic [14:0] addr_step;

	// bit reversal for LSB-first frames
	function automatic logic [15:0] sicr_rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction

	function automatic logic [7:0] sicr_rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction

	// register read decode
	function automatic logic [7:0] sicr_read(input logic [14:0] a, input logic [3:1] ca,
			input logic [4:0] cb, input logic [2:0] tg);
		logic [3:0] m;
		m = {ca, tg[BIT_SELF_RESET]};
		unique case (a)
			// mirror copies
			// mirror bits
			ADDR_CFG_A:      return {m[0], m[1], m[2], m[3], m};
			ADDR_CFG_B:      return {cb, tg[BIT_AUX1], tg[BIT_AUX0], 1'b0};
			ADDR_CHIP_CLASS: return CHIP_CLASS;
			ADDR_PROD_LOW:   return PART_ID[7:0];
			ADDR_PROD_HIGH:  return PART_ID[15:8];
			default:         return UNMAPPED;
		endcase
	endfunction

	// next-state logic
	always_comb begin
		st_next   = st_reg;
		// pin synchronisers
		st_next.sclk_s1 = SPI_SCLK_IN;
		st_next.sclk_s2 = st_reg.sclk_s1;
		st_next.sclk_s3 = st_reg.sclk_s2;
		st_next.cs_n_s1 = SPI_CS_N_IN;
		st_next.cs_n_s2 = st_reg.cs_n_s1;
		st_next.din_s1  = SPI_SDIO_IN;
		st_next.din_s2  = st_reg.din_s1;
		sclk_rise = st_reg.sclk_s2 & ~st_reg.sclk_s3;
		sclk_fall = ~st_reg.sclk_s2 & st_reg.sclk_s3;
		low_first = st_reg.cfg_a[BIT_LOW_FIRST];
		sh_new    = {st_reg.shift[14:0], st_reg.din_s2};
		word      = low_first ? sicr_rev16(sh_new) : sh_new;
		wr_byte   = low_first ? sicr_rev8(sh_new[7:0]) : sh_new[7:0];
		instr_end = 1'b0;
		byte_end  = 1'b0;
		addr_step = st_reg.cfg_a[BIT_STREAM_UP] ? st_reg.addr + 15'h0001 : st_reg.addr - 15'h0001;

		// reset pulse timers; completion clears the trigger and, for the main one, the modes
		for (int i = 0; i < 3; i++) begin
			if (st_reg.pulse_cnt[i*3 +: 3] != 3'h0) begin
				st_next.pulse_cnt[i*3 +: 3] = st_reg.pulse_cnt[i*3 +: 3] - 3'h1;
				if (st_reg.pulse_cnt[i*3 +: 3] == 3'h1) begin
					st_next.trig[i] = 1'b0;
					if (i == BIT_SELF_RESET) begin
						st_next.cfg_a    = CFG_A_RESET;
						st_next.cfg_b_hi = CFG_B_HI_RESET;
					end
				end
			end
		end

		// frame tracking
		unique case (st_reg.phase)
			PH_IDLE: begin
				if (!st_reg.cs_n_s2) begin
					st_next.phase   = PH_INSTR;
					st_next.bit_cnt = 4'h0;
				end
			end
			PH_INSTR: begin
				if (sclk_rise) begin
					st_next.shift   = sh_new;
					st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
					if (st_reg.bit_cnt == INSTR_LAST) begin
						instr_end        = 1'b1;
						st_next.phase    = PH_DATA;
						st_next.bit_cnt  = 4'h0;
						st_next.rw       = word[15];
						st_next.addr     = word[14:0];
						st_next.out_byte = sicr_read(word[14:0], st_reg.cfg_a, st_reg.cfg_b_hi, st_reg.trig);
					end
				end
			end
			PH_DATA: begin
				if (sclk_rise) begin
					st_next.shift   = sh_new;
					st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
					if (st_reg.bit_cnt == BYTE_LAST) begin
						byte_end         = 1'b1;
						st_next.bit_cnt  = 4'h0;
						st_next.addr     = addr_step;
						st_next.out_byte = sicr_read(addr_step, st_next.cfg_a, st_next.cfg_b_hi, st_next.trig);
						// writes after timer clears: a new trigger wins
						if (!st_reg.rw && st_reg.addr == ADDR_CFG_A) begin
							st_next.cfg_a = wr_byte[BIT_FOUR_WIRE:BIT_LOW_FIRST];
							if (wr_byte[BIT_SELF_RESET]) begin
								st_next.trig[BIT_SELF_RESET]    = 1'b1;
								st_next.pulse_cnt[2:0]          = PULSE_CYC;
							end
						end
						if (!st_reg.rw && st_reg.addr == ADDR_CFG_B) begin
							st_next.cfg_b_hi = wr_byte[7:CFG_B_HI];
							if (wr_byte[BIT_AUX1]) begin
								st_next.trig[BIT_AUX1]  = 1'b1;
								st_next.pulse_cnt[8:6]  = PULSE_CYC;
							end
							if (wr_byte[BIT_AUX0]) begin
								st_next.trig[BIT_AUX0]  = 1'b1;
								st_next.pulse_cnt[5:3]  = PULSE_CYC;
							end
						end
						st_next.out_byte = sicr_read(addr_step, st_next.cfg_a, st_next.cfg_b_hi, st_next.trig);
					end
				end
			end
		endcase

		// read data goes out on the falling edge
		if (st_reg.phase == PH_DATA && st_reg.rw && sclk_fall) begin
			st_next.sdio_out = low_first ? st_reg.out_byte[st_reg.bit_cnt[2:0]]
				: st_reg.out_byte[3'h7 - st_reg.bit_cnt[2:0]];
			st_next.sdo_out  = st_next.sdio_out;
		end
		// 4-wire uses SDO, 3-wire turns SDIO round
		st_next.sdio_oe = (st_reg.phase == PH_DATA) && st_reg.rw && !st_reg.cfg_a[BIT_FOUR_WIRE]
			&& !st_reg.cs_n_s2;

		// chip select released ends the frame
		if (st_reg.cs_n_s2) begin
			st_next.phase   = PH_IDLE;
			st_next.sdio_oe = 1'b0;
		end
		for (int i = 0; i < 3; i++) begin
			st_next.rst_out[i] = st_next.pulse_cnt[i*3 +: 3] != 3'h0;
		end
	end

	// state register
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_reg         <= '0;
			st_reg.phase   <= PH_IDLE;
			// select flops start deselected, so no false frame start follows reset
			st_reg.cs_n_s1 <= 1'b1;
			st_reg.cs_n_s2 <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops
	assign SPI_SDIO_OUT    = st_reg.sdio_out;
	assign SPI_SDIO_OE_OUT = st_reg.sdio_oe;
	assign SPI_SDO_OUT     = st_reg.sdo_out;
	assign SOFT_RESET_OUT  = st_reg.rst_out[BIT_SELF_RESET];
	assign AUX_RESET0_OUT  = st_reg.rst_out[BIT_AUX0];
	assign AUX_RESET1_OUT  = st_reg.rst_out[BIT_AUX1];

	// checks
	default clocking cb_main @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);

	property p_four_wire;
		SPI_SDIO_OE_OUT |-> !$past(st_reg.cfg_a[BIT_FOUR_WIRE]);
	endproperty
	a_four_wire: assert property (p_four_wire) else $error("sdio driven in 4-wire mode");

	property p_stream_step;
		byte_end |=> st_reg.addr == ($past(st_reg.cfg_a[BIT_STREAM_UP]) ? $past(st_reg.addr) + 15'h0001
			: $past(st_reg.addr) - 15'h0001);
	endproperty
	a_stream_step: assert property (p_stream_step) else $error("stream address step wrong");

	property p_bit_order;
		(st_reg.phase == PH_DATA && st_reg.rw && sclk_fall && !st_reg.cs_n_s2) |=> SPI_SDO_OUT ==
			($past(low_first) ? $past(st_reg.out_byte[st_reg.bit_cnt[2:0]])
			: $past(st_reg.out_byte[3'h7 - st_reg.bit_cnt[2:0]]));
	endproperty
	a_bit_order: assert property (p_bit_order) else $error("read bit order wrong");

	property p_soft_pulse;
		$rose(SOFT_RESET_OUT) |-> SOFT_RESET_OUT[*4] ##1 !SOFT_RESET_OUT;
	endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse length wrong");

	property p_mirror;
		(instr_end && word[14:0] == ADDR_CFG_A) |=> st_reg.out_byte[7:4] ==
			{st_reg.out_byte[0], st_reg.out_byte[1], st_reg.out_byte[2], st_reg.out_byte[3]};
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bits differ");

	property p_aux1;
		$rose(AUX_RESET1_OUT) |-> (AUX_RESET1_OUT && st_reg.trig[BIT_AUX1])[*4] ##1 !AUX_RESET1_OUT;
	endproperty
	a_aux1: assert property (p_aux1) else $error("aux reset one pulse wrong");

	property p_aux0;
		$fell(AUX_RESET0_OUT) |-> $past(AUX_RESET0_OUT, 4) && !$past(AUX_RESET0_OUT, 5);
	endproperty
	a_aux0: assert property (p_aux0) else $error("aux reset zero pulse wrong");

	property p_part_identifier;
		(instr_end && word[14:0] == ADDR_PROD_LOW) |=> st_reg.out_byte == PART_ID[7:0] ##8 1'b1;
	endproperty
	a_part_identifier: assert property (p_part_identifier) else $error("product id low byte wrong");

endmodule // sicr_regs

/* File: tb/sicr_host_model.sv */
// sicr_host_model: serial host that drives frames into the register bank.
// assumes the system clock; one serial clock lasts 8 system cycles (200 ns).
`timescale 1ns/100ps
module sicr_host_model (
	input  wire logic clk_in,
	input  wire logic sdio_in,
	input  wire logic sdo_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdio_out
);
	// idle: serial clock low and still, chip deselected
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdio_out = 1'b0;
	end

	// one serial clock; the read bit is taken just before the next fall
	task automatic bit_io(input logic b, input logic use_sdo, output logic q);
		sdio_out <= b;
		repeat (4) @(posedge clk_in);
		sclk_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		q = use_sdo ? sdo_in : sdio_in;
		sclk_out <= 1'b0;
	endtask

	// one frame: instruction word, then nb bytes from wd; read bytes come back in rd
	task automatic frame(input logic rw, input logic [14:0] a, input int nb, input logic lsb,
			input logic use_sdo, input logic [15:0] wd, output logic [15:0] rd);
		logic [15:0] ins;
		logic        q;
		int          k;
		ins = {rw, a};
		rd  = 16'h0000;
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		// bit order of instruction and data
		for (int i = 0; i < 16; i++) begin
			bit_io(ins[lsb ? i : 15 - i], 1'b0, q);
		end
		for (int i = 0; i < 8 * nb; i++) begin
			k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
			bit_io(wd[k], use_sdo, q);
			rd[k] = q;
		end
		repeat (4) @(posedge clk_in);
		cs_n_out <= 1'b1;
		// a released line no longer shows its last level
		sdio_out <= ~sdio_out;
		repeat (8) @(posedge clk_in);
	endtask
endmodule // sicr_host_model

/* File: tb/sicr_regs_tb.sv */
// sicr_regs_tb: self-checking bench for the configuration register bank.
// assumes the host model drives the serial pins; the bench resolves the data wire.
`timescale 1ns/100ps
module sicr_regs_tb;
	import sicr_pkg::*;
	logic        mclk = 1'b0;
	logic        rst  = 1'b1;
	logic        sclk, cs_n, host_sdio, sdio_w, sdio_dut, sdio_oe, sdo;
	logic        soft_rst, aux0, aux1;
	logic [15:0] rd;
	int          n_mismatch  = 0;
	int          comparisons = 0;
	int          cycles = 0, n_soft = 0, n_aux0 = 0, n_aux1 = 0, n_oe = 0, oe_before;

	always #12.5 mclk = ~mclk;
	// shared data wire: the device wins while it drives
	assign sdio_w = sdio_oe ? sdio_dut : host_sdio;

	sicr_regs i_dut (.MCLK_IN(mclk), .RST_IN(rst), .SPI_SCLK_IN(sclk), .SPI_CS_N_IN(cs_n),
		.SPI_SDIO_IN(sdio_w), .SPI_SDIO_OUT(sdio_dut), .SPI_SDIO_OE_OUT(sdio_oe), .SPI_SDO_OUT(sdo),
		.SOFT_RESET_OUT(soft_rst), .AUX_RESET0_OUT(aux0), .AUX_RESET1_OUT(aux1));
	sicr_host_model i_host (.clk_in(mclk), .sdio_in(sdio_w), .sdo_in(sdo), .sclk_out(sclk),
		.cs_n_out(cs_n), .sdio_out(host_sdio));

	// pulse widths, drive watch and cycle ceiling
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (soft_rst === 1'b1) n_soft <= n_soft + 1;
		if (aux0 === 1'b1) n_aux0 <= n_aux0 + 1;
		if (aux1 === 1'b1) n_aux1 <= n_aux1 + 1;
		if (sdio_oe === 1'b1) n_oe <= n_oe + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			final_report();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic lsb);
		i_host.frame(1'b0, a, 1, lsb, 1'b0, {8'h00, d}, rd);
	endtask

	task automatic rdc(input logic [14:0] a, input int nb, input logic lsb, input logic use_sdo,
			input logic [15:0] exp);
		i_host.frame(1'b1, a, nb, lsb, use_sdo, 16'h0000, rd);
		check(rd, exp);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// main sequence of register frames
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		// reset values, id bytes, unmapped place, refused write
		rdc(ADDR_CFG_A, 1, 1'b0, 1'b0, 16'h0000);
		rdc(ADDR_CFG_B, 1, 1'b0, 1'b0, 16'h0000);
		rdc(ADDR_PROD_LOW, 1, 1'b0, 1'b0, 16'h0034);
		rdc(ADDR_PROD_HIGH, 1, 1'b0, 1'b0, 16'h0012);
		rdc(15'h0002, 1, 1'b0, 1'b0, 16'h0000);
		wr(ADDR_CHIP_CLASS, 8'hFF, 1'b0);
		rdc(ADDR_CHIP_CLASS, 1, 1'b0, 1'b0, 16'h005A);
		// streaming up, then down
		wr(ADDR_CFG_A, 8'h04, 1'b0);
		rdc(ADDR_CFG_A, 1, 1'b0, 1'b0, 16'h0024);
		rdc(ADDR_CHIP_CLASS, 2, 1'b0, 1'b0, 16'h345A);
		wr(ADDR_CFG_A, 8'h00, 1'b0);
		rdc(ADDR_PROD_HIGH, 2, 1'b0, 1'b0, 16'h3412);
		// low bit leading on reads and on a write
		wr(ADDR_CFG_A, 8'h02, 1'b0);
		rdc(ADDR_PROD_LOW, 2, 1'b1, 1'b0, 16'h5A34);
		rdc(ADDR_CFG_A, 1, 1'b1, 1'b0, 16'h0042);
		wr(ADDR_CFG_A, 8'h0C, 1'b1);
		// four-wire read leaves the shared wire alone
		oe_before = n_oe;
		rdc(ADDR_CFG_A, 1, 1'b0, 1'b1, 16'h003C);
		check(16'(n_oe), 16'(oe_before));
		// soft reset pulse and return to defaults
		wr(ADDR_CFG_A, 8'h0D, 1'b0);
		check(16'(n_soft), 16'h0004);
		rdc(ADDR_CFG_A, 1, 1'b0, 1'b0, 16'h0000);
		// auxiliary reset lines one at a time
		wr(ADDR_CFG_B, 8'h02, 1'b0);
		check(16'(n_aux0), 16'h0004);
		check(16'(n_aux1), 16'h0000);
		wr(ADDR_CFG_B, 8'h04, 1'b0);
		check(16'(n_aux1), 16'h0004);
		rdc(ADDR_CFG_B, 1, 1'b0, 1'b0, 16'h0000);
		final_report();
	end
endmodule // sicr_regs_tb
